// ---- rtl/clk_speed_cfg.svh ----
// Constants of the clock speed select and reset block
`ifndef CLK_SPEED_CFG_SVH
`define CLK_SPEED_CFG_SVH

// Register indices; the byte address is four times the index
`define CKS_IDX_SPEED 8'h8F
`define CKS_IDX_STATUS 8'h90

// Reset value of the speed control register
`define CKS_SPEED_RST 8'h00

// Field positions inside the speed control register
`define CKS_BIT_CAN 7
`define CKS_BIT_WD 6
`define CKS_BIT_CNT_ARRAY 5
`define CKS_BIT_SER 4
`define CKS_BIT_T2 3
`define CKS_BIT_T1 2
`define CKS_BIT_T0 1
`define CKS_BIT_DBL 0

// Field positions inside the status register
`define CKS_STAT_RST 0
`define CKS_STAT_PIN_RST 1
`define CKS_STAT_INT_RST 2
`define CKS_STAT_PIN_LVL 3

// Oscillator periods per cycle, standard and double speed
`define CKS_STD_PERIOD 12
`define CKS_DBL_PERIOD 6

// Machine cycles the reset pin must stay high
`define CKS_RST_MCYCLES 2

// Number of peripheral strobes
`define CKS_NUM_PERIPH 7

`endif

// ---- rtl/clk_speed_pkg.sv ----
// Types shared by the clock speed select and reset block
package clk_speed_pkg;

  // Speed control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic can;
    logic watchdog;
    logic counter_array;
    logic serial;
    logic timer_two;
    logic timer_one;
    logic timer_zero;
    logic global_double_speed;
  } speed_ctl_t;

  // Status register layout, low nibble
  typedef struct packed {
    logic pin_level;
    logic int_rst;
    logic pin_rst;
    logic rst_active;
  } rst_status_t;

endpackage

// ---- rtl/cycle_strobe_gen.sv ----
// Counter that emits a one-period strobe every 6 or 12 oscillator periods
`timescale 1ns/1ps
`include "clk_speed_cfg.svh"

module cycle_strobe_gen
  import clk_speed_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Rate control
  input wire logic fast,
  input wire logic restart,
  // Cycle strobe
  output logic stb
);

  logic [CNT_W-1:0] cnt_r; // Periods elapsed in this cycle
  logic [CNT_W-1:0] cnt_nxt; // Next count
  logic [CNT_W-1:0] last_w; // Last count of the cycle
  logic wrap_w; // Cycle ends this period
  logic stb_r; // Registered strobe

  // Cycle length from the selected rate
  assign last_w = fast ? CNT_W'(`CKS_DBL_PERIOD - 1) : CNT_W'(`CKS_STD_PERIOD - 1);
  assign wrap_w = (cnt_r == last_w);
  // Restart reloads the count so a rate change never leaves a stale, overlong cycle
  assign cnt_nxt = (restart || wrap_w) ? '0 : cnt_r + 1'b1;

  // Count and strobe registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      stb_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      stb_r <= wrap_w && !restart;
    end
  end

  assign stb = stb_r;

endmodule

// ---- rtl/clock_speed_select.sv ----
// Clock speed select, cycle strobe generation and warm reset qualification
//
// Contract
// RULE1: Machine cycle 12 periods, or 6 doubled
// RULE2: Peripheral bit clear 6 periods, set 12
// RULE3: Peripheral bits ignored while global bit low
// RULE4: Bits 7..0 CAN down to global select
// RULE5: Reset clears the whole speed register
// RULE6: Reset pin counts after two machine cycles
// RULE7: Warm reset from pin or internal source
// RULE8: Outside holds pin until supply stable
// RULE9: Strobes from counters, reloaded on change
`timescale 1ns/1ps
`include "clk_speed_cfg.svh"

module clock_speed_select
  import clk_speed_pkg::*;
(
  // Clock and asynchronous reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Reset pin and internal reset requests
  input wire logic RST_PIN,
  input wire logic [2:0] INT_RST_REQ,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Cycle strobes
  output logic MACH_STB,
  output logic [`CKS_NUM_PERIPH-1:0] PERIPH_STB,
  // Warm reset to the core and peripherals
  output logic RST_OUT
);

  // Reset release
  logic [1:0] arst_sync_r; // Two-stage release of the external reset
  logic rst_n_s; // Released reset used everywhere below

  // Register file
  speed_ctl_t speed_r; // Speed control register
  speed_ctl_t speed_nxt; // Its next value
  logic restart_w; // Any speed bit changes this edge

  // Wishbone decode
  logic req_w; // New request, not yet answered
  logic hit_speed_w; // Address selects the speed register
  logic hit_status_w; // Address selects the status register
  logic wr_speed_w; // Write to the low byte of the speed register
  logic [31:0] rdata_w; // Read data before registering
  logic ack_r; // Acknowledge
  logic [31:0] dat_r; // Registered read data
  rst_status_t status_w; // Status fields

  // Reset pin qualification
  logic [2:0] pin_sync_r; // Three-stage pin synchroniser
  logic pin_hi_r; // Filtered pin level
  logic pin_hi_nxt; // Its next value
  logic [4:0] pin_cnt_r; // Periods the pin has stayed high
  logic [4:0] pin_cnt_nxt; // Its next value
  logic [4:0] pin_thr_w; // Periods in two machine cycles
  logic pin_rst_r; // Pin reset qualified
  logic pin_rst_nxt; // Its next value
  logic int_req_w; // Any internal reset source
  logic rst_out_r; // Combined warm reset

  // Strobe generation
  logic [`CKS_NUM_PERIPH:0] fast_w; // Per counter double-speed select
  logic [`CKS_NUM_PERIPH:0] stb_w; // Counter strobes, index 0 is the core

  // Release the asynchronous reset through two flip-flops
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      arst_sync_r <= 2'h0;
    end
    else
    begin
      arst_sync_r <= {arst_sync_r[0], 1'b1};
    end
  end

  assign rst_n_s = arst_sync_r[1];

  // Bus decode; each register takes one word at four times its index
  assign req_w = WB_CYC_I && WB_STB_I && !ack_r;
  assign hit_speed_w = (WB_ADR_I[9:2] == `CKS_IDX_SPEED);
  assign hit_status_w = (WB_ADR_I[9:2] == `CKS_IDX_STATUS);
  // Only byte lane 0 carries the register; the write lands at the edge that sees ack high
  assign wr_speed_w = WB_CYC_I && WB_STB_I && ack_r && WB_WE_I && WB_SEL_I[0] && hit_speed_w;

  // Next speed value; a warm reset wins over a write in the same cycle
  assign speed_nxt = rst_out_r ? speed_ctl_t'(`CKS_SPEED_RST) : // RULE5
                     wr_speed_w ? speed_ctl_t'(WB_DAT_I[7:0]) : speed_r; // RULE4
  // Any change reloads all counters so they stay in phase
  assign restart_w = (speed_nxt != speed_r); // RULE9

  // Status fields seen by software
  assign status_w.rst_active = rst_out_r;
  assign status_w.pin_rst = pin_rst_r;
  assign status_w.int_rst = int_req_w;
  assign status_w.pin_level = pin_hi_r;

  // Read mux; unmapped addresses answer with zero
  assign rdata_w = hit_speed_w ? {24'h000000, speed_r} :
                   hit_status_w ? {28'h0000000, status_w} : 32'h00000000;

  // Speed register
  always_ff @(posedge MCLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      speed_r <= speed_ctl_t'(`CKS_SPEED_RST); // RULE5
    end
    else
    begin
      speed_r <= speed_nxt;
    end
  end

  // Bus answer: one acknowledge per request, dropped the cycle after
  always_ff @(posedge MCLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= req_w;
      dat_r <= req_w ? rdata_w : 32'h00000000;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // Pin filter: a new level counts once stages two and three agree
  assign pin_hi_nxt = (pin_sync_r[2] == pin_sync_r[1]) ? pin_sync_r[2] : pin_hi_r;

  // Two machine cycles at the current core rate
  assign pin_thr_w = speed_r.global_double_speed ? 5'(`CKS_RST_MCYCLES * `CKS_DBL_PERIOD) :
                     5'(`CKS_RST_MCYCLES * `CKS_STD_PERIOD); // RULE6
  // High time counter, saturating so a long pulse does not wrap
  assign pin_cnt_nxt = !pin_hi_r ? 5'h00 :
                       (pin_cnt_r == 5'h1F) ? pin_cnt_r : pin_cnt_r + 5'h01;
  // Latched once qualified, so the rate change caused by reset cannot drop it
  assign pin_rst_nxt = pin_hi_r && (pin_rst_r || (pin_cnt_r == pin_thr_w - 5'h01)); // RULE6

  // Internal sources: watchdog, counter array, timer
  assign int_req_w = |INT_RST_REQ; // RULE7

  // Pin synchroniser, filter and qualification
  always_ff @(posedge MCLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      pin_sync_r <= 3'h0;
      pin_hi_r <= 1'b0;
      pin_cnt_r <= 5'h00;
      pin_rst_r <= 1'b0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], RST_PIN};
      pin_hi_r <= pin_hi_nxt;
      pin_cnt_r <= pin_cnt_nxt;
      pin_rst_r <= pin_rst_nxt;
    end
  end

  // Warm reset; the pin alone must be held long enough by the outside
  always_ff @(posedge MCLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      rst_out_r <= 1'b0;
    end
    else
    begin
      rst_out_r <= pin_rst_r || int_req_w; // RULE7
    end
  end

  assign RST_OUT = rst_out_r;

  // Core counter doubles with the global bit alone
  assign fast_w[0] = speed_r.global_double_speed; // RULE1

  // One counter per peripheral; its bit matters only in double-speed mode
  for (genvar i = 1; i <= `CKS_NUM_PERIPH; i++)
  begin : g_periph_rate
    assign fast_w[i] = speed_r.global_double_speed && !speed_r[i]; // RULE2 RULE3
  end

  // Counters for the core and every peripheral
  for (genvar i = 0; i <= `CKS_NUM_PERIPH; i++)
  begin : g_strobe
    cycle_strobe_gen #(
      .CNT_W(4)
    ) u_gen (
      .clk(MCLK),
      .rst_n(rst_n_s),
      .fast(fast_w[i]),
      .restart(restart_w),
      .stb(stb_w[i])
    ); // RULE9
  end

  assign MACH_STB = stb_w[0];
  assign PERIPH_STB = stb_w[`CKS_NUM_PERIPH:1];

  // Helper counters that only the checks below read
  logic [7:0] quiet_r; // Cycles since the last rate change
  logic [7:0] mgap_r; // Cycles since the last core strobe
  logic [7:0] pgap_r; // Cycles since the last timer zero strobe

  // Gap and quiet counters, saturating
  always_ff @(posedge MCLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      quiet_r <= 8'h00;
      mgap_r <= 8'h00;
      pgap_r <= 8'h00;
    end
    else
    begin
      quiet_r <= restart_w ? 8'h00 : (quiet_r == 8'hFF) ? quiet_r : quiet_r + 8'h01;
      mgap_r <= MACH_STB ? 8'h00 : (mgap_r == 8'hFF) ? mgap_r : mgap_r + 8'h01;
      pgap_r <= PERIPH_STB[0] ? 8'h00 : (pgap_r == 8'hFF) ? pgap_r : pgap_r + 8'h01;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking

  default disable iff (!rst_n_s);

  // Core strobe spacing follows the global bit once settled
  chk_mach_period: assert property ( // RULE1
    MACH_STB && quiet_r > 8'h1A |->
      mgap_r == (speed_r.global_double_speed ? 8'h05 : 8'h0B))
    else $error("core strobe spacing wrong");

  // Timer zero strobe spacing follows its own bit in double mode
  chk_periph_period: assert property ( // RULE2
    PERIPH_STB[0] && quiet_r > 8'h1A |->
      pgap_r == ((speed_r.global_double_speed && !speed_r.timer_zero) ? 8'h05 : 8'h0B))
    else $error("peripheral strobe spacing wrong");

  // With the global bit low every peripheral ticks with the core
  chk_std_lockstep: assert property ( // RULE3
    !speed_r.global_double_speed |-> PERIPH_STB == {`CKS_NUM_PERIPH{MACH_STB}})
    else $error("peripheral rate differs in standard mode");

  // A written byte lands in the register bit for bit
  chk_write_map: assert property ( // RULE4
    wr_speed_w && !rst_out_r |=> speed_r == speed_ctl_t'($past(WB_DAT_I[7:0])))
    else $error("speed register write lost");

  // Warm reset leaves the speed register cleared; the clearing edge also restarts the core count
  chk_reset_clear: assert property ( // RULE5
    rst_out_r |=> speed_r == speed_ctl_t'(`CKS_SPEED_RST) && !(MACH_STB && $past(restart_w)))
    else $error("speed register not cleared by reset");

  // Pin reset qualifies exactly at two machine cycles of high level
  chk_pin_qualify: assert property ( // RULE6
    $rose(pin_rst_r) |-> $past(pin_cnt_r) == $past(pin_thr_w) - 5'h01 && $past(pin_hi_r))
    else $error("pin reset qualified at wrong time");

  // A low pin ends the pin reset on the next edge
  chk_pin_drop: assert property ( // RULE6
    !pin_hi_r |=> !pin_rst_r ##1 !rst_out_r || int_req_w || $past(int_req_w))
    else $error("pin reset outlived the pin");

  // Any internal source raises warm reset one edge later
  chk_int_reset: assert property ( // RULE7
    int_req_w |=> RST_OUT)
    else $error("internal reset not honoured");

  // The core strobe lasts one period and never repeats back to back
  chk_strobe_single: assert property ( // RULE9
    MACH_STB |=> !MACH_STB)
    else $error("core strobe longer than one period");

  // A rate change always restarts the core count
  chk_restart_reload: assert property ( // RULE9
    restart_w |=> !MACH_STB [*5])
    else $error("strobe too soon after rate change");

  // Acknowledge is a single-cycle pulse
  chk_ack_pulse: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held too long");

  // Main scenarios
  cov_double_core: cover property (MACH_STB && speed_r.global_double_speed);
  cov_mixed_rate: cover property (MACH_STB && !PERIPH_STB[0] && speed_r.timer_zero);
  cov_pin_reset: cover property ($rose(pin_rst_r));
  cov_int_reset: cover property (int_req_w && !pin_rst_r);

endmodule

// ---- testbench/strobe_consumer.sv ----
// Cycle strobe consumer that measures the spacing of its enable pulses
`timescale 1ns/1ps

module strobe_consumer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enable strobe from the clock block
  input wire logic stb,
  // Periods between the last two strobes
  output logic [7:0] gap_r
);
  logic [7:0] cnt_r; // Periods since the last strobe

  // Restart the count on each strobe; a lone strobe after a reload gives an odd gap, so read late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h00;
      gap_r <= 8'h00;
    end
    else if (stb)
    begin
      gap_r <= cnt_r + 8'h01;
      cnt_r <= 8'h00;
    end
    else
      cnt_r <= cnt_r + 8'h01;
  end
endmodule

// ---- testbench/clock_speed_select_tb.sv ----
// Self-checking bench for the clock speed select and reset block
`timescale 1ns/1ps

module clock_speed_select_tb;
  import clk_speed_pkg::*;
  localparam logic [9:0] SPEED_ADR = 10'h23C; // Speed control register
  localparam logic [9:0] HOLE_ADR = 10'h3FC; // Unmapped address
  localparam logic [9:0] STATUS_ADR = 10'h240; // Read-only status register
  logic [3:0] sel = 4'h1; // Byte enables
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic rst_pin = 1'b0;
  logic [2:0] int_req = 3'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic mach_stb;
  logic [6:0] periph_stb;
  logic rst_out;
  wire [7:0] all_stb = {periph_stb, mach_stb}; // Index equals register bit
  wire [7:0] gap [8]; // Measured spacing per strobe
  logic [31:0] rd; // Last read data
  logic seen; // Warm reset seen during a pin pulse
  speed_ctl_t cfg;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] corner [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};

  // 100 MHz oscillator
  always #5 mclk = ~mclk;

  clock_speed_select u_clock_speed_select (.MCLK(mclk), .ARST_N(arst_n), .RST_PIN(rst_pin),
    .INT_RST_REQ(int_req), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .MACH_STB(mach_stb),
    .PERIPH_STB(periph_stb), .RST_OUT(rst_out));

  // One consumer per strobe, core first
  for (genvar i = 0; i < 8; i++)
  begin : g_cons
    strobe_consumer u_strobe_consumer (.clk(mclk), .rst_n(arst_n), .stb(all_stb[i]), .gap_r(gap[i]));
  end

  // Expected periods per cycle; peripheral bits count only at double speed
  function automatic logic [7:0] exp_gap(logic [7:0] r, int i);
    if (i == 0)
      return r[0] ? 8'h06 : 8'h0C;
    return (r[0] && !r[i]) ? 8'h06 : 8'h0C;
  endfunction

  // Compare one result word
  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic Wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(logic w, logic [9:0] a, logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Raise the reset pin for len cycles, watch for a warm reset then and for 12 cycles after
  task automatic pin_pulse(int len);
    seen = 1'b0;
    @(posedge mclk);
    rst_pin <= 1'b1;
    repeat (len) @(posedge mclk) seen |= rst_out;
    rst_pin <= 1'b0;
    repeat (12) @(posedge mclk) seen |= rst_out;
  endtask

  // Verdict and end of run
  task automatic stop_test;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    void'($urandom(91));
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wb_xfer(1'b0, SPEED_ADR, 32'h0);
    cmp_val(rd, 32'h0);
    wb_xfer(1'b1, HOLE_ADR, 32'hFF);
    wb_xfer(1'b0, HOLE_ADR, 32'h0);
    cmp_val(rd, 32'h0);
    // A write without lane 0 must leave the register alone
    sel <= 4'h0;
    wb_xfer(1'b1, SPEED_ADR, 32'hFF);
    sel <= 4'h1;
    wb_xfer(1'b0, SPEED_ADR, 32'h0);
    cmp_val(rd, 32'h0);
    // Corner rates first, then random ones; upper bytes must be ignored
    for (int n = 0; n < 12; n++)
    begin
      cfg = (n < 4) ? corner[n] : 8'($urandom);
      wb_xfer(1'b1, SPEED_ADR, {24'($urandom), cfg});
      wb_xfer(1'b0, SPEED_ADR, 32'h0);
      cmp_val(rd, {24'h0, cfg});
      repeat (40) @(posedge mclk);
      for (int i = 0; i < 8; i++)
        cmp_val({24'h0, gap[i]}, {24'h0, exp_gap(cfg, i)});
    end
    // Pin pulses at standard then double rate: short ignored, long resets
    for (int k = 0; k < 2; k++)
    begin
      wb_xfer(1'b1, SPEED_ADR, {31'h0, k[0]});
      // One period short of two machine cycles
      pin_pulse(k ? 11 : 23);
      cmp_val({31'h0, seen}, 32'h0);
      wb_xfer(1'b1, SPEED_ADR, k ? 32'hFF : 32'hFE);
      pin_pulse(k ? 40 : 60);
      cmp_val({31'h0, seen}, 32'h1);
      wb_xfer(1'b0, SPEED_ADR, 32'h0);
      cmp_val(rd, 32'h0);
    end
    // Each internal source gives a warm reset that clears the register
    for (int k = 0; k < 3; k++)
    begin
      wb_xfer(1'b1, SPEED_ADR, 32'hFF);
      int_req <= 3'h1 << k;
      @(posedge mclk);
      @(negedge mclk);
      cmp_val({31'h0, rst_out}, 32'h1);
      @(posedge mclk);
      int_req <= 3'h0;
      repeat (3) @(posedge mclk);
      cmp_val({31'h0, rst_out}, 32'h0);
      wb_xfer(1'b0, SPEED_ADR, 32'h0);
      cmp_val(rd, 32'h0);
    end
    // Status while an internal request is held, then idle again
    int_req <= 3'h4;
    wb_xfer(1'b0, STATUS_ADR, 32'h0);
    cmp_val(rd, 32'h5);
    int_req <= 3'h0;
    repeat (4) @(posedge mclk);
    wb_xfer(1'b0, STATUS_ADR, 32'h0);
    cmp_val(rd, 32'h0);
    stop_test();
  end
endmodule
